// ---- bench/rcb_serial_host.sv ----
// partner model: controller side of the serial register port
`timescale 1ns/1ps
module rcb_serial_host
(
  // serial register port
  output logic serialClk,
  output logic serialSelN,
  output logic serialIn,
  input wire logic serialOut
);
  // ====================
  // idle: clock still, select high
  initial
  begin
    serialClk = 1'b0;
    serialSelN = 1'b1;
    serialIn = 1'b0;
  end

  // ====================
  // one frame: rw, address, data, msb first, 160 ns clock
  task automatic xfer(input logic rw, input logic [6:0] adr, input logic [7:0] wd,
    output logic [7:0] rd);
    logic [15:0] frm;
    frm = {rw, adr, wd};
    rd = 8'h00;
    #1.7;
    serialSelN = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      serialIn = frm[i];
      #80;
      serialClk = 1'b1;
      #80;
      serialClk = 1'b0;
      if (i < 8)
        rd[i] = serialOut;
    end
    serialIn = ~serialIn;
    #80;
    serialSelN = 1'b1;
    #80;
  endtask
endmodule

// ---- bench/receiver_control_bank_test.sv ----
// testbench of the receiver control bank
`timescale 1ns/1ps
module receiver_control_bank_test;
  import rcb_pkg::*;
  // ====================
  // signals
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic serialClk, serialSelN, serialIn, serialOut;
  rcb_events_t events = 8'h00;
  rcb_queue_t queue = 5'h00;
  rcb_pins_t pinSrc = 4'hb;
  logic levelIndicator = 1'b0;
  logic [7:0] signalLevelValue = 8'h00;
  logic [2:0] operationStateReadback = 3'h5;
  logic [1:0] dataMode = 2'h0;
  logic outputPinOne, outputPinTwo, outputPinThree, outputPinFour;
  logic irqLineOne, irqLineTwo, fastSerialEnable, sleepTimerHalt, productionTestEnable;
  logic [4:0] operationSwitchRequest;
  logic softResetPulse;
  logic [7:0] softResetCode;
  int nFail = 0;
  int testsRun = 0;
  int srCount = 0;

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (softResetPulse === 1'b1)
      srCount++;

  rcb_control_bank #(.SYNC_STAGES(3)) uut (.ref_clk, .rst_n, .clkEn, .serialClk,
    .serialSelN, .serialIn, .serialOut, .events, .queue, .pinSrc, .levelIndicator,
    .signalLevelValue, .operationStateReadback, .dataMode, .outputPinOne, .outputPinTwo,
    .outputPinThree, .outputPinFour, .irqLineOne, .irqLineTwo, .fastSerialEnable,
    .sleepTimerHalt, .productionTestEnable, .operationSwitchRequest, .softResetPulse,
    .softResetCode);
  rcb_serial_host mdl (.serialClk, .serialSelN, .serialIn, .serialOut);

  // ====================
  // compares and verdict
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp, input string what);
    testsRun++;
    if (got !== exp)
    begin
      nFail++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chkBit(input logic got, input logic exp, input string what);
    testsRun++;
    if (got !== exp)
    begin
      nFail++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  task automatic endOfTest();
    $display("counts: %0d compares, %0d mismatches", testsRun, nFail);
    if (nFail == 0 && testsRun > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ====================
  // bus and stimulus tasks
  task automatic regWr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    mdl.xfer(RW_WRITE, a, d, r);
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic regRd(input logic [6:0] a, output logic [7:0] d);
    mdl.xfer(~RW_WRITE, a, 8'h00, d);
    @(negedge ref_clk);
  endtask
  task automatic pulseEv(input logic [7:0] e);
    events = e;
    @(negedge ref_clk);
    events = 8'h00;
    repeat (3) @(negedge ref_clk);
  endtask

  // ====================
  // expected line source by code and mode
  function automatic logic srcVal(input logic [3:0] c, input logic [1:0] md,
    input logic [7:0] f, input rcb_queue_t q, input logic ind);
    logic [15:0] s;
    s = 16'h0000;
    s[3:0] = {f[3], f[4], f[5], 1'b0};
    if (md == MODE_DIRECT)
      s[6:4] = {ind, f[6], f[7]};
    else if (md == MODE_BUFFER)
      s[11:4] = {ind, q.overflow, q.writeStrobe, q.full, q.threshold, q.notEmpty, f[6], f[7]};
    else if (md == MODE_PACKET)
      s[14:4] = {ind, q.overflow, q.writeStrobe, q.full, q.threshold, q.notEmpty, f[6], f[7],
        f[0], f[1], f[2]};
    else
      s = 16'h0000;
    return s[c];
  endfunction

  initial
  begin
    #600000;
    nFail++;
    $display("Error at %0t: timeout", $time);
    endOfTest();
  end

  // ====================
  // main sequence
  initial
  begin
    logic [7:0] d, v, m, e, c, n;
    logic [6:0] rA [10] = '{7'h3f, 7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h46, 7'h47, 7'h4f, 7'h50};
    logic [7:0] rV [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'ha0, 8'h00, 8'h00};
    logic [6:0] rwA [3] = '{ADR_IRQ_ENABLE, ADR_PIN_SELECT, ADR_ROUTE_SELECT};
    logic [3:0] p4, p3, p2, p1;
    d = 8'($urandom(43));
    repeat (16) @(negedge ref_clk);
    chkBit(fastSerialEnable, 1'b1, "reset fse");
    chkBit(outputPinOne, 1'b0, "reset pin");
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    chkBit(outputPinFour, 1'b1, "pin4 default");
    chkBit(outputPinThree, 1'b1, "pin3 default");
    chkBit(outputPinTwo, 1'b0, "pin2 default");
    chkBit(outputPinOne, 1'b1, "pin1 default");
    for (int j = 0; j < 10; j++)
    begin
      regRd(rA[j], v);
      chkByte(v, rV[j], "reset value");
    end
    $display("test reset done");
    for (int k = 0; k < 4; k++)
    begin
      signalLevelValue = 8'($urandom);
      operationStateReadback = 3'($urandom);
      queue = 5'({$urandom} & 32'h1e);
      for (int j = 0; j < 3; j++)
      begin
        d = 8'($urandom);
        regWr(rwA[j], d);
        regRd(rwA[j], v);
        chkByte(v, d, "rw reg");
      end
      d = 8'($urandom);
      regWr(ADR_FUNC_ENABLE, d);
      regRd(ADR_FUNC_ENABLE, v);
      chkByte(v, d & FUNC_MASK, "func");
      chkBit(fastSerialEnable, d[2], "fse");
      chkBit(sleepTimerHalt, d[6], "halt");
      chkBit(productionTestEnable, d[5], "ptest");
      regWr(ADR_OP_CONTROL, d);
      regRd(ADR_OP_CONTROL, v);
      chkByte(v, {operationStateReadback, d[4:0]}, "opctl");
      chkByte({3'h0, operationSwitchRequest}, {3'h0, d[4:0]}, "switch");
      regWr(ADR_LEVEL_VALUE, d);
      regRd(ADR_LEVEL_VALUE, v);
      chkByte(v, signalLevelValue, "level");
      regWr(7'h50, d);
      regRd(7'h50, v);
      chkByte(v, 8'h00, "unmapped");
      regRd(ADR_QUEUE_FLAGS, v);
      chkByte(v, {1'b0, queue.full, queue.notEmpty, queue.threshold, queue.overflow, 3'h0},
        "queue");
      n = 8'(srCount);
      regWr(ADR_SOFT_RESET, d);
      chkByte(8'(srCount) - n, 8'h01, "srst pulses");
      chkByte(softResetCode, d, "srst code");
    end
    $display("test registers done");
    regWr(ADR_IRQ_CLEAR, 8'hff);
    for (int k = 0; k < 4; k++)
    begin
      m = 8'($urandom);
      e = 8'($urandom);
      c = 8'($urandom);
      regWr(ADR_IRQ_ENABLE, m);
      pulseEv(e);
      clkEn = 1'b0;
      pulseEv(~e);
      clkEn = 1'b1;
      regRd(ADR_IRQ_FLAGS, v);
      chkByte(v, m & e, "flags");
      regWr(ADR_IRQ_CLEAR, c);
      regRd(ADR_IRQ_FLAGS, v);
      chkByte(v, m & e & ~c, "clear");
      regWr(ADR_IRQ_CLEAR, 8'hff);
    end
    $display("test flags done");
    regWr(ADR_IRQ_ENABLE, 8'hff);
    for (int code = 0; code < 16; code++)
    begin
      regWr(ADR_ROUTE_SELECT, {4'(code), 4'(code)});
      regWr(ADR_IRQ_CLEAR, 8'hff);
      e = 8'($urandom);
      pulseEv(e);
      for (int md = 0; md < 4; md++)
      begin
        dataMode = 2'(md);
        queue = 5'({$urandom} & 32'h1e);
        levelIndicator = 1'($urandom);
        repeat (3) @(negedge ref_clk);
        v[0] = srcVal(4'(code), dataMode, e, queue, levelIndicator);
        chkBit(irqLineOne, v[0], "line one");
        chkBit(irqLineTwo, v[0], "line two");
        queue.writeStrobe = 1'b1;
        v[1] = srcVal(4'(code), dataMode, e, queue, levelIndicator);
        @(negedge ref_clk);
        queue.writeStrobe = 1'b0;
        n = {7'h00, irqLineOne};
        repeat (3)
        begin
          @(negedge ref_clk);
          n = n + {7'h00, irqLineOne};
        end
        chkByte(n, v[0] ? 8'h04 : {7'h00, v[1]}, "strobe");
      end
    end
    $display("test routing done");
    dataMode = MODE_DIRECT;
    regWr(ADR_IRQ_CLEAR, 8'hff);
    pulseEv(8'h20);
    regWr(ADR_ROUTE_SELECT, 8'h21);
    for (int s = 0; s < 4; s++)
    begin
      regWr(ADR_PIN_SELECT, {4{2'(s)}});
      repeat (2)
      begin
        pinSrc = 4'($urandom);
        repeat (3) @(negedge ref_clk);
        p4 = {pinSrc.dataSyncClock, 1'b0, 1'b1, pinSrc.dataOut};
        p3 = {pinSrc.dataOut, 1'b0, 1'b1, pinSrc.systemClockOut};
        p2 = {1'b0, pinSrc.dataSyncClock, 1'b0, 1'b1};
        p1 = {pinSrc.dataOut, 1'b0, 1'b1, pinSrc.powerOnResetOutN};
        chkBit(outputPinFour, p4[s], "pin4");
        chkBit(outputPinThree, p3[s], "pin3");
        chkBit(outputPinTwo, p2[s], "pin2");
        chkBit(outputPinOne, p1[s], "pin1");
      end
    end
    $display("test pins done");
    endOfTest();
  end
endmodule

// ---- src/rcb_control_bank.sv ----
// control bank of the receiver: serial register port, interrupts, pin routing
`timescale 1ns/1ps

module rcb_control_bank
  import rcb_pkg::*;
#(
  parameter int SYNC_STAGES = 3
)
(
  // system clock
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // serial register port
  input wire logic serialClk,
  input wire logic serialSelN,
  input wire logic serialIn,
  output logic serialOut,
  // device status
  input wire rcb_events_t events,
  input wire rcb_queue_t queue,
  input wire rcb_pins_t pinSrc,
  input wire logic levelIndicator,
  input wire logic [7:0] signalLevelValue,
  input wire logic [2:0] operationStateReadback,
  input wire logic [1:0] dataMode,
  // pins and interrupts
  output logic outputPinOne,
  output logic outputPinTwo,
  output logic outputPinThree,
  output logic outputPinFour,
  output logic irqLineOne,
  output logic irqLineTwo,
  // control outputs
  output logic fastSerialEnable,
  output logic sleepTimerHalt,
  output logic productionTestEnable,
  output logic [4:0] operationSwitchRequest,
  output logic softResetPulse,
  output logic [7:0] softResetCode
);

  // ==========================================
  // parameter check
  if (SYNC_STAGES < 3)
  begin : g_bad
    $error("SYNC_STAGES below 3");
  end

  // ==========================================
  // state
  typedef struct packed {
    logic [4:0] bitCount;
    logic addrDone;
    logic writeDone;
    logic sdo;
  } rcb_link_t;
  typedef struct packed {
    logic [15:0] frame;
    logic [7:0] tx;
  } rcb_link_data_t;
  typedef struct packed {
    logic [SYNC_STAGES-1:0] wrSync;
    logic [SYNC_STAGES-1:0] rdSync;
    logic wrLvl;
    logic rdLvl;
    rcb_events_t irqEnable;
    rcb_pin_sel_t pinSelect;
    rcb_route_t routeSelect;
    rcb_events_t flags;
    logic [7:0] funcEnable;
    logic [4:0] opSwitch;
    logic [7:0] readData;
    logic irqOne;
    logic irqTwo;
    logic [3:0] pinOut;
    logic softPulse;
    logic [7:0] softCode;
  } rcb_state_t;
  localparam rcb_state_t ST_RESET = '{funcEnable: RST_FUNC_ENABLE, default: '0};
  rcb_link_t lk_r;
  rcb_link_t lk_nxt;
  rcb_link_data_t dt_r;
  rcb_link_data_t dt_nxt;
  rcb_state_t st_r;
  rcb_state_t st_nxt;
  logic wrLvlNew;
  logic rdLvlNew;
  logic wrFire;
  logic rdFire;
  logic [6:0] wrAddr;
  logic [7:0] wrData;
  logic [6:0] rdAddr;
  logic [7:0] clearMask;
  logic [15:0] srcVec;

  // ==========================================
  // source picker shared by both lines
  function automatic logic pickSource(
    input logic [3:0] code,
    input logic [1:0] mode,
    input logic [15:0] src
  );
    logic [63:0] map;
    map = '0;
    case (mode)
      MODE_DIRECT: map = MAP_DIRECT;
      MODE_BUFFER: map = MAP_BUFFER;
      MODE_PACKET: map = MAP_PACKET;
      default: map = '0;
    endcase
    return src[map[{code, 2'b00} +: 4]];
  endfunction

  function automatic logic pickPin(input logic [1:0] sel, input logic [3:0] choice);
    return choice[sel];
  endfunction

  // ==========================================
  // link side: frame shifter on the serial clock
  always_comb
  begin
    lk_nxt = lk_r;
    dt_nxt = dt_r;
    if (lk_r.bitCount != CNT_END)
    begin
      lk_nxt.bitCount = lk_r.bitCount + 5'h01;
      dt_nxt.frame = {dt_r.frame[14:0], serialIn};
    end
    if (lk_r.bitCount == CNT_ADDR_LAST)
    begin
      lk_nxt.addrDone = 1'b1;
    end
    if (lk_r.bitCount == CNT_LAST && dt_r.frame[14] == RW_WRITE)
    begin
      lk_nxt.writeDone = 1'b1;
    end
    if (lk_r.bitCount == CNT_DATA_FIRST)
    begin
      {lk_nxt.sdo, dt_nxt.tx} = {st_r.readData, 1'b0};
    end
    else if (lk_r.bitCount > CNT_DATA_FIRST && lk_r.bitCount <= CNT_LAST)
    begin
      {lk_nxt.sdo, dt_nxt.tx} = {dt_r.tx, 1'b0};
    end
  end

  // frame control ends with the select line
  always_ff @(posedge serialClk or posedge serialSelN)
  begin
    if (serialSelN)
    begin
      lk_r <= '0;
    end
    else
    begin
      lk_r <= lk_nxt;
    end
  end
  always_ff @(posedge serialClk)
  begin
    if (!serialSelN)
    begin
      dt_r <= dt_nxt;
    end
  end
  assign serialOut = lk_r.sdo;

  // ==========================================
  // crossing: filtered levels qualify the held frame
  assign wrLvlNew = (st_r.wrSync[SYNC_STAGES-1] == st_r.wrSync[SYNC_STAGES-2]) ?
                    st_r.wrSync[SYNC_STAGES-1] : st_r.wrLvl;
  assign rdLvlNew = (st_r.rdSync[SYNC_STAGES-1] == st_r.rdSync[SYNC_STAGES-2]) ?
                    st_r.rdSync[SYNC_STAGES-1] : st_r.rdLvl;
  assign wrFire = wrLvlNew & ~st_r.wrLvl;
  assign rdFire = rdLvlNew & ~st_r.rdLvl;
  assign wrAddr = dt_r.frame[14:8];
  assign wrData = dt_r.frame[7:0];
  assign rdAddr = dt_r.frame[6:0];
  assign clearMask = (wrFire && wrAddr == ADR_IRQ_CLEAR) ? wrData : '0;
  // sources indexed as the tables expect
  assign srcVec = {1'b0, queue.overflow, queue.writeStrobe, queue.full,
                   queue.threshold, queue.notEmpty, st_r.flags.packetFinished,
                   st_r.flags.checksumPass, st_r.flags.nodePass, levelIndicator,
                   st_r.flags.receiveTimeout, st_r.flags.sleepTimeout,
                   st_r.flags.syncwordPass, st_r.flags.preamblePass,
                   st_r.flags.levelValid, 1'b0};

  // ==========================================
  // register side
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.wrSync = {st_r.wrSync[SYNC_STAGES-2:0], lk_r.writeDone};
    st_nxt.rdSync = {st_r.rdSync[SYNC_STAGES-2:0], lk_r.addrDone};
    st_nxt.wrLvl = wrLvlNew;
    st_nxt.rdLvl = rdLvlNew;
    st_nxt.softPulse = 1'b0;

    // flags: set wins over clear
    st_nxt.flags = (st_r.flags & ~clearMask)
                   | (events & st_r.irqEnable);

    if (wrFire)
    begin
      case (wrAddr)
        ADR_IRQ_ENABLE: st_nxt.irqEnable = wrData;
        ADR_PIN_SELECT: st_nxt.pinSelect = wrData;
        ADR_ROUTE_SELECT: st_nxt.routeSelect = wrData;
        ADR_FUNC_ENABLE: st_nxt.funcEnable = wrData & FUNC_MASK;
        ADR_OP_CONTROL: st_nxt.opSwitch = wrData[4:0];
        ADR_SOFT_RESET:
        begin
          st_nxt.softPulse = 1'b1;
          st_nxt.softCode = wrData;
        end
        default: st_nxt.softPulse = 1'b0;
      endcase
    end

    if (rdFire)
    begin
      case (rdAddr)
        ADR_IRQ_ENABLE: st_nxt.readData = st_r.irqEnable;
        ADR_PIN_SELECT: st_nxt.readData = st_r.pinSelect;
        ADR_ROUTE_SELECT: st_nxt.readData = st_r.routeSelect;
        ADR_IRQ_FLAGS: st_nxt.readData = st_r.flags;
        ADR_QUEUE_FLAGS: st_nxt.readData = {1'b0, queue.full, queue.notEmpty,
                                           queue.threshold, queue.overflow, 3'b000};
        ADR_LEVEL_VALUE: st_nxt.readData = signalLevelValue;
        ADR_FUNC_ENABLE: st_nxt.readData = st_r.funcEnable;
        ADR_OP_CONTROL: st_nxt.readData = {operationStateReadback, st_r.opSwitch};
        default: st_nxt.readData = '0;
      endcase
    end

    // interrupt lines
    st_nxt.irqTwo = pickSource(st_r.routeSelect.two, dataMode, srcVec);
    st_nxt.irqOne = pickSource(st_r.routeSelect.one, dataMode, srcVec);
    // pins, choices listed from code 3 down to code 0
    st_nxt.pinOut[3] = pickPin(st_r.pinSelect.four, {pinSrc.dataSyncClock, st_r.irqTwo,
                               st_r.irqOne, pinSrc.dataOut});
    st_nxt.pinOut[2] = pickPin(st_r.pinSelect.three, {pinSrc.dataOut, st_r.irqTwo,
                               st_r.irqOne, pinSrc.systemClockOut});
    st_nxt.pinOut[1] = pickPin(st_r.pinSelect.two, {1'b0, pinSrc.dataSyncClock,
                               st_r.irqTwo, st_r.irqOne});
    st_nxt.pinOut[0] = pickPin(st_r.pinSelect.one, {pinSrc.dataOut, st_r.irqTwo,
                               st_r.irqOne, pinSrc.powerOnResetOutN});
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_r <= ST_RESET;
    end
    else if (clkEn)
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // outputs
  assign outputPinFour = st_r.pinOut[3];
  assign outputPinThree = st_r.pinOut[2];
  assign outputPinTwo = st_r.pinOut[1];
  assign outputPinOne = st_r.pinOut[0];
  assign irqLineOne = st_r.irqOne;
  assign irqLineTwo = st_r.irqTwo;
  assign fastSerialEnable = st_r.funcEnable[2];
  assign sleepTimerHalt = st_r.funcEnable[6];
  assign productionTestEnable = st_r.funcEnable[5];
  assign operationSwitchRequest = st_r.opSwitch;
  assign softResetPulse = st_r.softPulse;
  assign softResetCode = st_r.softCode;

  // ==========================================
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_enable_write: assert property (
    clkEn && wrFire && wrAddr == ADR_IRQ_ENABLE |=> st_r.irqEnable == $past(wrData))
    else $error("enable register not written");

  a_level_read: assert property (
    clkEn && rdFire && rdAddr == ADR_LEVEL_VALUE |=> st_r.readData == $past(signalLevelValue))
    else $error("level value not read back");

  a_func_reset: assert property (
    !$past(rst_n) |-> st_r.funcEnable == RST_FUNC_ENABLE && fastSerialEnable)
    else $error("function enable reset value wrong");

  a_switch_write: assert property (
    clkEn && wrFire && wrAddr == ADR_OP_CONTROL |=> operationSwitchRequest == $past(wrData[4:0]))
    else $error("switch request not written");

  a_soft_pulse: assert property (
    clkEn && wrFire && wrAddr == ADR_SOFT_RESET |=> softResetPulse ##1
    (!softResetPulse || !$past(clkEn)))
    else $error("soft reset pulse wrong");
  a_sleep_gate: assert property (
    clkEn && events.sleepTimeout && st_r.irqEnable.sleepTimeout |=> st_r.flags.sleepTimeout)
    else $error("sleep flag not set");

  a_rx_block: assert property (
    clkEn && !st_r.irqEnable.receiveTimeout && !st_r.flags.receiveTimeout
    |=> !st_r.flags.receiveTimeout)
    else $error("receive flag set while disabled");

  a_flag_gate: assert property (
    clkEn |=> (st_r.flags & ~$past(st_r.flags)) == ($past(events & st_r.irqEnable)
              & ~$past(st_r.flags)))
    else $error("flag set without enabled event");

  a_sync_gate: assert property (
    clkEn && events.syncwordPass && st_r.irqEnable.syncwordPass |=> st_r.flags.syncwordPass)
    else $error("sync flag not set");

  a_node_gate: assert property (
    clkEn && events.nodePass && st_r.irqEnable.nodePass |=> st_r.flags.nodePass)
    else $error("node flag not set");

  a_packet_gate: assert property (
    clkEn && events.packetFinished && st_r.irqEnable.packetFinished
    |=> st_r.flags.packetFinished)
    else $error("packet flag not set");

  a_pin_four: assert property (
    clkEn && st_r.pinSelect.four == PSEL_ALT |=> outputPinFour == $past(pinSrc.dataSyncClock))
    else $error("pin four route wrong");

  a_pin_three: assert property (
    clkEn && st_r.pinSelect.three == PSEL_ALT |=> outputPinThree == $past(pinSrc.dataOut))
    else $error("pin three route wrong");

  a_pin_two: assert property (
    clkEn && st_r.pinSelect.two == PSEL_ALT |=> !outputPinTwo)
    else $error("pin two not zero");

  a_pin_one: assert property (
    clkEn && st_r.pinSelect.one == PSEL_DEF |=> outputPinOne == $past(pinSrc.powerOnResetOutN))
    else $error("pin one route wrong");

  a_route_zero: assert property (
    clkEn && st_r.routeSelect.two == 4'h0 |=> !irqLineTwo)
    else $error("line two not zero");

  a_buffer_strobe: assert property (
    clkEn && dataMode == MODE_BUFFER && st_r.routeSelect.two == 4'h9
    |=> irqLineTwo == $past(queue.writeStrobe))
    else $error("buffer strobe route wrong");

  a_packet_done: assert property (
    clkEn && dataMode == MODE_PACKET && st_r.routeSelect.two == 4'h6
    |=> irqLineTwo == $past(st_r.flags.packetFinished))
    else $error("packet done route wrong");

  a_lines_match: assert property (
    clkEn && st_r.routeSelect.one == st_r.routeSelect.two |=> irqLineOne == irqLineTwo)
    else $error("line one differs from line two");

  a_clear_flag: assert property (
    clkEn && clearMask[0] && !events.packetFinished |=> !st_r.flags.packetFinished)
    else $error("flag not cleared");

  c_write: cover property (clkEn && wrFire);
  c_read: cover property (clkEn && rdFire && rdAddr == ADR_IRQ_FLAGS);
  c_line_two: cover property (dataMode == MODE_PACKET && irqLineTwo);
  c_set_clear: cover property (clkEn && clearMask[7] && events.sleepTimeout);

endmodule

// ---- src/rcb_pkg.sv ----
// package: register map, source tables and carriers of the control bank
package rcb_pkg;

  // ==========================================
  // register map
  localparam logic [6:0] ADR_IRQ_ENABLE = 7'h3f;
  localparam logic [6:0] ADR_PIN_SELECT = 7'h40;
  localparam logic [6:0] ADR_ROUTE_SELECT = 7'h41;
  localparam logic [6:0] ADR_IRQ_CLEAR = 7'h42;
  localparam logic [6:0] ADR_IRQ_FLAGS = 7'h43;
  localparam logic [6:0] ADR_QUEUE_FLAGS = 7'h44;
  localparam logic [6:0] ADR_LEVEL_VALUE = 7'h45;
  localparam logic [6:0] ADR_FUNC_ENABLE = 7'h46;
  localparam logic [6:0] ADR_OP_CONTROL = 7'h47;
  localparam logic [6:0] ADR_SOFT_RESET = 7'h4f;
  localparam logic [7:0] RST_FUNC_ENABLE = 8'h04;
  localparam logic [7:0] FUNC_MASK = 8'h64;

  // ==========================================
  // serial frame: rw bit, 7 address bits, 8 data bits
  localparam logic [4:0] CNT_ADDR_LAST = 5'h07;
  localparam logic [4:0] CNT_DATA_FIRST = 5'h08;
  localparam logic [4:0] CNT_LAST = 5'h0f;
  localparam logic [4:0] CNT_END = 5'h10;
  localparam logic RW_WRITE = 1'b0;

  // ==========================================
  // data modes and source tables, one nibble per code
  localparam logic [1:0] MODE_DIRECT = 2'h0;
  localparam logic [1:0] MODE_BUFFER = 2'h1;
  localparam logic [1:0] MODE_PACKET = 2'h2;
  localparam logic [63:0] MAP_DIRECT = 64'h0000_0000_0654_3210;
  localparam logic [63:0] MAP_BUFFER = 64'h0000_6edc_ba54_3210;
  localparam logic [63:0] MAP_PACKET = 64'h06ed_cba5_4987_3210;

  // ==========================================
  // pin select codes
  localparam logic [1:0] PSEL_DEF = 2'h0;
  localparam logic [1:0] PSEL_IRQ1 = 2'h1;
  localparam logic [1:0] PSEL_IRQ2 = 2'h2;
  localparam logic [1:0] PSEL_ALT = 2'h3;

  // ==========================================
  // carriers
  typedef struct packed {
    logic sleepTimeout;
    logic receiveTimeout;
    logic levelValid;
    logic preamblePass;
    logic syncwordPass;
    logic nodePass;
    logic checksumPass;
    logic packetFinished;
  } rcb_events_t;

  typedef struct packed {
    logic full;
    logic notEmpty;
    logic threshold;
    logic overflow;
    logic writeStrobe;
  } rcb_queue_t;

  typedef struct packed {
    logic dataOut;
    logic dataSyncClock;
    logic systemClockOut;
    logic powerOnResetOutN;
  } rcb_pins_t;

  typedef struct packed {
    logic [1:0] four;
    logic [1:0] three;
    logic [1:0] two;
    logic [1:0] one;
  } rcb_pin_sel_t;

  typedef struct packed {
    logic [3:0] two;
    logic [3:0] one;
  } rcb_route_t;

endpackage
